// ===== pbs_pkg.sv
// constants for the bridge pwm steering block
package pbs_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int DB_WIDTH = 7;
	localparam int TMR_WIDTH = 8;
	localparam int TOSC_PER_TCY = 4;
	localparam logic [1:0] TCY_LAST = 2'(TOSC_PER_TCY - 1);
	localparam logic [1:0] TCY_RESET = 2'h0;
	localparam logic [TMR_WIDTH-1:0] HANDOVER_TICKS = 8'h04;
	localparam logic [DB_WIDTH-1:0] DB_RESET = 7'h00;
	localparam logic DIR_FORWARD = 1'b0;
	localparam logic DIR_RESET = DIR_FORWARD;
	localparam logic OUT_ACTIVE = 1'b1;
	localparam logic OUT_INACTIVE = 1'b0;
	localparam logic OUT_RESET = OUT_INACTIVE;

	typedef enum logic [1:0] {
		PBS_ST_RUN = 2'b01,
		PBS_ST_HOLD = 2'b10
	} pbs_state_e;
endpackage

// ===== pbs_deadband.sv
// rising-edge dead-band delay for one half-bridge output
`timescale 1ns/100ps
module pbs_deadband import pbs_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tcy_stb,
	input wire logic in_lvl,
	input wire logic [DB_WIDTH-1:0] db_len,
	output logic out_q
);
	logic [DB_WIDTH-1:0] cnt_q;

	// delay on the rising edge only, falling edge passes at once
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= DB_RESET;
			out_q <= OUT_RESET;
		end else if (ce) begin
			if (!in_lvl) begin
				out_q <= OUT_INACTIVE;
				cnt_q <= db_len;
			end else if (out_q != OUT_ACTIVE) begin
				if (cnt_q == DB_RESET) begin
					out_q <= OUT_ACTIVE;
				end else if (tcy_stb) begin
					cnt_q <= cnt_q - 7'h01;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_DB_FALL_FAST: assert property (ce && !in_lvl |=> out_q == OUT_INACTIVE)
		else $error("dead-band output stayed active after input fell");
	AST_DB_ZERO: assert property (
		ce && in_lvl && out_q == OUT_INACTIVE && cnt_q == DB_RESET |=> out_q == OUT_ACTIVE)
		else $error("expired dead-band did not release output");
	AST_DB_HOLDS: assert property (
		ce && in_lvl && out_q == OUT_INACTIVE && cnt_q != DB_RESET |=> out_q == OUT_INACTIVE)
		else $error("output asserted before dead-band count expired");
endmodule // pbs_deadband

// ===== pbs_steer.sv
// output steering for full-bridge and half-bridge pwm
// Behaviour
// - in full-bridge mode the direction bit picks forward or reverse, taking effect at the next hand-over start.
// - the direction bit may change at any time without corrupting the cycle in progress.
// - a pending direction change starts the hand-over four timer ticks before period end.
// - at hand-over start both modulated outputs b and d go inactive.
// - at hand-over start the unmodulated outputs a and c swap to the new direction.
// - modulation resumes on the newly selected output when the next period begins.
// - the hold interval runs over the last timer ticks, each one prescaled timer step long.
// - full-bridge mode applies no dead-band delay.
// - in half-bridge mode dead-band delays only the inactive-to-active edge.
// - dead-band length is the low seven control bits in instruction cycles of four clocks.
`timescale 1ns/100ps
module pbs_steer import pbs_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic full_bridge_mode,
	input wire logic direction_select_bit,
	input wire logic [7:0] steering_control_reg,
	input wire logic pwm_mod,
	input wire logic tmr_tick,
	input wire logic [TMR_WIDTH-1:0] tmr_count,
	input wire logic [TMR_WIDTH-1:0] tmr_period,
	output logic bridge_out_a,
	output logic bridge_out_b,
	output logic bridge_out_c,
	output logic bridge_out_d,
	output logic handover_active
);
	pbs_state_e st_q;
	pbs_state_e st_d;
	logic dir_q;
	logic [1:0] tcy_q;
	logic tcy_stb;
	logic period_end;
	logic early_pt;
	logic dir_pend;
	logic start_ho;
	logic [DB_WIDTH-1:0] db_len;
	logic [1:0] half_in;
	logic [1:0] half_out;
	logic a_d;
	logic b_d;
	logic c_d;
	logic d_d;

	// timer position within the period
	assign period_end = tmr_tick && (tmr_count == tmr_period);
	assign early_pt = tmr_tick && (tmr_count == TMR_WIDTH'(tmr_period - HANDOVER_TICKS));
	// direction is only sampled here, so late writes wait a period
	assign dir_pend = (direction_select_bit != dir_q);
	assign start_ho = full_bridge_mode && (st_q == PBS_ST_RUN) && early_pt && dir_pend;
	assign db_len = steering_control_reg[DB_WIDTH-1:0];

	// instruction cycle strobe, one every four clocks
	assign tcy_stb = (tcy_q == TCY_LAST);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tcy_q <= TCY_RESET;
		end else if (ce) begin
			tcy_q <= tcy_q + 2'h1;
		end
	end

	// hand-over sequencer
	always_comb begin
		st_d = st_q;
		case (st_q)
			PBS_ST_RUN: begin
				if (start_ho) begin
					st_d = PBS_ST_HOLD;
				end
			end
			PBS_ST_HOLD: begin
				if (period_end || !full_bridge_mode) begin
					st_d = PBS_ST_RUN;
				end
			end
			default: begin
				st_d = PBS_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= PBS_ST_RUN;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// applied direction, swapped only at hand-over start
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dir_q <= DIR_RESET;
		end else if (ce && start_ho) begin
			dir_q <= direction_select_bit;
		end
	end

	// half-bridge dead-band, one delay per output
	assign half_in[0] = pwm_mod;
	assign half_in[1] = !pwm_mod;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_db
			pbs_deadband u_db (
				.clk(clk),
				.resetn(resetn),
				.ce(ce),
				.tcy_stb(tcy_stb),
				.in_lvl(half_in[i]),
				.db_len(db_len),
				.out_q(half_out[i])
			);
		end
	endgenerate

	// output steering
	always_comb begin
		a_d = OUT_INACTIVE;
		b_d = OUT_INACTIVE;
		c_d = OUT_INACTIVE;
		d_d = OUT_INACTIVE;
		if (full_bridge_mode) begin
			// no dead-band path in full-bridge
			if (dir_q == DIR_FORWARD) begin
				a_d = OUT_ACTIVE;
				d_d = (st_q == PBS_ST_RUN) && pwm_mod;
			end else begin
				c_d = OUT_ACTIVE;
				b_d = (st_q == PBS_ST_RUN) && pwm_mod;
			end
		end else begin
			a_d = half_out[0];
			b_d = half_out[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bridge_out_a <= OUT_RESET;
			bridge_out_b <= OUT_RESET;
			bridge_out_c <= OUT_RESET;
			bridge_out_d <= OUT_RESET;
		end else if (ce) begin
			bridge_out_a <= a_d;
			bridge_out_b <= b_d;
			bridge_out_c <= c_d;
			bridge_out_d <= d_d;
		end
	end

	// hold window covers the last timer ticks of the period
	assign handover_active = (st_q == PBS_ST_HOLD);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_start;
		ce && start_ho;
	endsequence

	sequence s_entered;
		st_q == PBS_ST_HOLD && dir_q == $past(direction_select_bit);
	endsequence

	sequence s_swapped;
		bridge_out_a == (dir_q == DIR_FORWARD) && bridge_out_c == (dir_q != DIR_FORWARD);
	endsequence

	AST_START_AT_FOUR: assert property (s_start |=> s_entered)
		else $error("hand-over did not start at the fourth tick before period end");
	AST_NO_START_ELSE: assert property (
		ce && st_q == PBS_ST_RUN && !early_pt |=> st_q == PBS_ST_RUN)
		else $error("hand-over started away from the fourth tick before end");
	AST_MODS_OFF: assert property (
		s_start ##1 (ce && full_bridge_mode)
		|=> bridge_out_b == OUT_INACTIVE && bridge_out_d == OUT_INACTIVE)
		else $error("modulated outputs active at hand-over start");
	AST_SWAP_AC: assert property (s_start ##1 (ce && full_bridge_mode) |=> s_swapped)
		else $error("unmodulated outputs did not swap at hand-over start");
	AST_HOLD_UNTIL_END: assert property (
		ce && st_q == PBS_ST_HOLD && full_bridge_mode && !period_end |=> st_q == PBS_ST_HOLD)
		else $error("modulation resumed before the next period");
	AST_RESUME: assert property (
		ce && st_q == PBS_ST_HOLD && period_end |=> st_q == PBS_ST_RUN)
		else $error("modulation did not resume at period start");
	AST_DIR_STABLE: assert property (ce && !start_ho |=> $stable(dir_q))
		else $error("direction changed outside the hand-over point");
	AST_FULL_NO_DB: assert property (
		ce && full_bridge_mode && st_q == PBS_ST_RUN && dir_q == DIR_FORWARD
		|=> bridge_out_d == $past(pwm_mod))
		else $error("full-bridge modulated output was delayed");
	AST_REV_NO_DB: assert property (
		ce && full_bridge_mode && st_q == PBS_ST_RUN && dir_q != DIR_FORWARD
		|=> bridge_out_b == $past(pwm_mod))
		else $error("full-bridge reverse modulated output was delayed");

	// steady steering during the hold and in each mode
	AST_HOLD_MODS_OFF: assert property (
		ce && full_bridge_mode && st_q == PBS_ST_HOLD
		|=> bridge_out_b == OUT_INACTIVE && bridge_out_d == OUT_INACTIVE)
		else $error("modulated output active during hand-over hold");
	AST_AC_FOLLOW: assert property (
		ce && full_bridge_mode
		|=> bridge_out_a == ($past(dir_q) == DIR_FORWARD)
		&& bridge_out_c == ($past(dir_q) != DIR_FORWARD))
		else $error("unmodulated outputs disagree with applied direction");
	AST_HALF_CD_OFF: assert property (
		ce && !full_bridge_mode
		|=> bridge_out_c == OUT_INACTIVE && bridge_out_d == OUT_INACTIVE)
		else $error("unused bridge outputs active in half-bridge mode");

	// resume after the hold
	sequence s_resume;
		ce && full_bridge_mode && st_q == PBS_ST_HOLD && period_end
		##1 ce && full_bridge_mode;
	endsequence

	AST_RESUME_MOD: assert property (
		s_resume
		|=> ($past(dir_q) == DIR_FORWARD ? bridge_out_d : bridge_out_b) == $past(pwm_mod))
		else $error("modulation missing on the selected output after resume");
endmodule // pbs_steer

// ===== pbs_gate_model.sv
// gate driver model of one external half-bridge leg
`timescale 1ns/100ps
module pbs_gate_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic half_mode,
	input wire logic gate_hi,
	input wire logic gate_lo,
	output logic [7:0] overlap_cnt
);
	// both switches on together means shoot-through
	always_ff @(posedge clk) begin
		if (!resetn) begin
			overlap_cnt <= 8'h00;
		end else if (half_mode && gate_hi && gate_lo) begin
			overlap_cnt <= overlap_cnt + 8'h01;
		end
	end
endmodule // pbs_gate_model

// ===== pbs_steer_tb.sv
// testbench for the bridge pwm steering block
`timescale 1ns/100ps
module pbs_steer_tb import pbs_pkg::*;;
	logic clk = 0, resetn = 0, fbm = 1, dir = 0, pwm = 0, tick = 0;
	logic [7:0] scr = 8'h00, cnt = 8'h00, per = 8'h0a;
	logic a, b, c, d, ho;
	logic [7:0] ovl;
	int err_count = 0, cmp_count = 0;

	pbs_steer pbs_steer_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .full_bridge_mode(fbm),
		.direction_select_bit(dir), .steering_control_reg(scr), .pwm_mod(pwm),
		.tmr_tick(tick), .tmr_count(cnt), .tmr_period(per), .bridge_out_a(a),
		.bridge_out_b(b), .bridge_out_c(c), .bridge_out_d(d), .handover_active(ho));
	pbs_gate_model pbs_gate_model_inst (.clk(clk), .resetn(resetn), .half_mode(!fbm),
		.gate_hi(a), .gate_lo(b), .overlap_cnt(ovl));

	initial begin
		forever #5 clk = ~clk;
	end

	task step;
		@(posedge clk);
		#1;
	endtask

	task check(input string name, input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", name, exp, seen);
		end
	endtask

	task tk(input int v);
		tick = 1;
		cnt = 8'(v);
		step;
		tick = 0;
		step;
		step;
	endtask

	task give_verdict;
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// forward drive, d follows pwm with no dead-band
	task fwd_run;
		fbm = 1;
		pwm = 1;
		repeat (3) step;
		check("a", a, 1'b1);
		check("c", c, 1'b0);
		pwm = 0;
		step;
		check("d", d, 1'b0);
		pwm = 1;
		step;
		check("d", d, 1'b1);
	endtask

	// reverse request mid-period, hold over last four ticks
	task reverse;
		pwm = 0;
		tk(0);
		dir = 1;
		for (int i = 1; i < 6; i++) tk(i);
		check("handover", ho, 1'b0);
		check("d", d, 1'b0);
		pwm = 1;
		tk(6);
		check("handover", ho, 1'b1);
		check("a", a, 1'b0);
		check("c", c, 1'b1);
		check("b", b, 1'b0);
		check("d", d, 1'b0);
		for (int i = 7; i < 10; i++) begin
			tk(i);
			check("hold", ho === 1'b1 && b === 1'b0 && d === 1'b0, 1'b1);
		end
		tk(10);
		check("b", b, 1'b1);
		check("handover", ho, 1'b0);
		check("c", c, 1'b1);
	endtask

	// half-bridge rising-edge delay of len instruction cycles
	task half_db(input logic [6:0] len);
		int n;
		fbm = 0;
		scr = {1'b0, len};
		pwm = 0;
		repeat (600) step;
		pwm = 1;
		n = 0;
		while (a !== 1'b1 && n < 600) begin
			step;
			n++;
		end
		check("a delay", n + 1 >= 4 * len && n <= 4 * len + 2, 1'b1);
		check("b", b, 1'b0);
		pwm = 0;
		step;
		step;
		check("a", a, 1'b0);
		check("overlap", ovl == 8'h00, 1'b1);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		resetn = 1;
		fwd_run;
		reverse;
		half_db(7'h00);
		half_db(7'h05);
		half_db(7'h7f);
		give_verdict;
	end

	initial begin
		#100000;
		err_count++;
		give_verdict;
	end
endmodule // pbs_steer_tb
